// *** bench/rcs_core_tb.sv ***
/*
 * Self-checking bench of rcs_core: APB master, event pulses, cause model.
 * Assumes rcs_regs.svh on the include path and rcs_pkg compiled first.
 */
`timescale 1ns/1ps
`include "rcs_regs.svh"

module rcs_core_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic droop = 1'h0;
  logic supply = 1'h1;
  logic opt = 1'h0;
  // Bits: external pin, watchdog, stop, halt exit, recovery pin
  logic [4:0] ev = 5'h00;
  logic [31:0] prdata;
  logic pready, pslverr, sys_reset, cpu_en, sys_en, xosc, ipo, xpins;
  logic porta, periph, wosc, wrun, drun, irq, rerr;
  logic [31:0] rdat;
  logic [11:0] a;
  logic [7:0] d;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 5657;
  int m_cause = 0;

  initial forever #25 clk = ~clk;

  // Short sequence keeps each reset to a handful of cycles
  rcs_core #(.SEQ_CYCLES(4)) dut (
    .CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DROOP_LOW(droop),
    .SUPPLY_ABOVE_POR(supply), .DROOP_DETECT_IN_STOP(opt),
    .EXT_RESET_PIN(ev[0]), .WDT_TIMEOUT(ev[1]), .STOP_EXEC(ev[2]),
    .HALT_EXIT(ev[3]), .RECOVER_PIN(ev[4]), .SYS_RESET(sys_reset),
    .CPU_CLK_EN(cpu_en), .SYS_CLK_EN(sys_en), .XTAL_OSC_EN(xosc),
    .IPO_EN(ipo), .XTAL_PINS_EN(xpins), .PORTA_GPIO(porta),
    .PERIPH_EN(periph), .WDT_OSC_RUN(wosc), .WDT_RUN(wrun),
    .DROOP_RUN(drun), .IRQ(irq)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [31:0] msk);
    n_compared++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // The watchdog pulse rides the access phase to collide with a read
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd, input logic wdt);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    ev[1] <= wdt;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 50) num_errors++;
    psel <= 1'h0;
    penable <= 1'h0;
    ev[1] <= 1'h0;
  endtask : apb

  task automatic rd(input logic [11:0] ad, input int exp,
                    input logic [31:0] msk);
    apb(1'h0, ad, 32'h0, 1'h0);
    chk(rdat, exp, msk);
  endtask : rd

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'h1;
    @(posedge clk);
    ev[b] <= 1'h0;
  endtask : pulse

  task automatic wait_run();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while ((sys_reset !== 1'h0 || cpu_en !== 1'h1) && n < 100);
    if (n >= 100) num_errors++;
  endtask : wait_run

  task automatic wdt_act();
    pulse(1);
    m_cause = (m_cause | 32'h20) & ~32'h40;
  endtask : wdt_act

  // Enter stop, try wrong wake sources and a droop, then wake by b
  task automatic stop_wake(input int b, input logic wen);
    pulse(2);
    tick(2);
    chk(32'({cpu_en, sys_en, xosc, ipo}), 32'h0, 32'hF);
    chk(32'({xpins, periph, porta}), 32'h1, 32'h7);
    chk(32'({wrun, wosc, drun}), 32'({wen, wen, opt}), 32'h7);
    @(posedge clk);
    droop <= 1'h1;
    pulse(3);
    if (!wen) pulse(1);
    droop <= 1'h0;
    tick(2);
    chk(32'({sys_reset, cpu_en}), 32'h0, 32'h3);
    pulse(b);
    wait_run();
  endtask : stop_wake

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    wait_run();
    rd(`RCS_OFF_CTRL, 32'h07, 32'hFFFFFFFF);
    rd(`RCS_OFF_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
    rd(`RCS_OFF_STATUS, 32'h80, 32'hFFFFFFFF);
    rd(`RCS_OFF_STATUS, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      a = 12'h010 | (12'($random(seed)) & 12'hFF0);
      d = 8'($random(seed));
      apb(1'h1, a, 32'(d), 1'h0);
      rd(a, 32'h0, 32'hFFFFFFFF);
      chk(32'(rerr), 32'h1, 32'h1);
      apb(1'h1, `RCS_OFF_IRQ_MASK, 32'(d), 1'h0);
      rd(`RCS_OFF_IRQ_MASK, 32'(d), 32'hFFFFFFFF);
    end
    @(posedge clk);
    droop <= 1'h1;
    supply <= 1'h0;
    tick(3);
    chk(32'(sys_reset), 32'h1, 32'h1);
    @(posedge clk);
    droop <= 1'h0;
    tick(4);
    chk(32'(sys_reset), 32'h1, 32'h1);
    @(posedge clk);
    supply <= 1'h1;
    wait_run();
    rd(`RCS_OFF_STATUS, 32'h80, 32'hFFFFFFFF);
    apb(1'h0, `RCS_OFF_IRQ_STAT, 32'h0, 1'h0);
    apb(1'h1, `RCS_OFF_IRQ_MASK, 32'h20, 1'h0);
    m_cause = 0;
    wdt_act();
    tick(1);
    chk(32'(irq), 32'h1, 32'h1);
    rd(`RCS_OFF_STATUS, m_cause, 32'hFFFFFFFF);
    rd(`RCS_OFF_IRQ_STAT, 32'h20, 32'hFFFFFFFF);
    tick(1);
    chk(32'(irq), 32'h0, 32'h1);
    pulse(0);
    wait_run();
    rd(`RCS_OFF_STATUS, 32'h90, 32'hFFFFFFFF);
    pulse(0);
    wait_run();
    m_cause = 32'h90;
    wdt_act();
    stop_wake(4, 1'h1);
    m_cause = (m_cause | 32'h40) & ~32'h30;
    rd(`RCS_OFF_STATUS, m_cause, 32'h70);
    stop_wake(1, 1'h1);
    rd(`RCS_OFF_STATUS, 32'h60, 32'h70);
    stop_wake(4, 1'h1);
    m_cause = 32'h40;
    wdt_act();
    rd(`RCS_OFF_STATUS, m_cause, 32'h70);
    apb(1'h0, `RCS_OFF_STATUS, 32'h0, 1'h1);
    rd(`RCS_OFF_STATUS, 32'h20, 32'h70);
    apb(1'h0, `RCS_OFF_IRQ_STAT, 32'h0, 1'h1);
    rd(`RCS_OFF_IRQ_STAT, 32'h20, 32'h20);
    apb(1'h1, `RCS_OFF_CTRL, 32'h0F, 1'h0);
    tick(2);
    chk(32'({cpu_en, sys_en, periph}), 32'h3, 32'h7);
    pulse(3);
    tick(1);
    chk(32'(cpu_en), 32'h1, 32'h1);
    rd(`RCS_OFF_CTRL, 32'h07, 32'hFF);
    apb(1'h1, `RCS_OFF_CTRL, 32'h04, 1'h0);
    stop_wake(4, 1'h0);
    rd(`RCS_OFF_STATUS, 32'h40, 32'h40);
    apb(1'h1, `RCS_OFF_CTRL, 32'h17, 1'h0);
    tick(1);
    chk(32'({xosc, xpins, porta, ipo}), 32'hD, 32'hF);
    @(posedge clk);
    opt <= 1'h1;
    pulse(2);
    tick(2);
    chk(32'(drun), 32'h1, 32'h1);
    chk(32'({xosc, xpins, porta, ipo}), 32'h2, 32'hF);
    @(posedge clk);
    droop <= 1'h1;
    supply <= 1'h0;
    tick(2);
    chk(32'(sys_reset), 32'h1, 32'h1);
    @(posedge clk);
    droop <= 1'h0;
    supply <= 1'h1;
    wait_run();
    rd(`RCS_OFF_STATUS, 32'h80, 32'h80);
    final_report();
  end

  initial begin
    #2000000;
    num_errors++;
    final_report();
  end
endmodule : rcs_core_tb

// *** pkg/rcs_pkg.sv ***
/*
 * Types of the reset-cause and stop-mode block.
 * Assumes rcs_regs.svh supplies the numeric constants.
 */
package rcs_pkg;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_SEQ = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_HALT = 3'b011,
    ST_STOP = 3'b100
  } rcs_mode_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcs_apb_req_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic xtal_osc_en;
    logic ipo_en;
    logic xtal_pins_en;
    logic porta_gpio;
    logic periph_en;
    logic wdt_osc_run;
    logic wdt_run;
    logic droop_run;
  } rcs_power_type;

  typedef struct packed {
    rcs_mode_type mode;
    logic [7:0] cause;
    logic [7:0] ctrl;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] seq_cnt;
    logic [31:0] prdata;
    logic ext_pend;
  } rcs_state_type;

endpackage : rcs_pkg

// *** pkg/rcs_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of
 * the reset-cause and stop-mode block.
 * Assumes a 32-bit APB with byte addresses and word-aligned registers.
 */
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RCS_OFF_STATUS 12'h000
`define RCS_OFF_CTRL 12'h004
`define RCS_OFF_IRQ_STAT 12'h008
`define RCS_OFF_IRQ_MASK 12'h00C

// ----------------------------------------------------------------------
// Cause status bit positions
// ----------------------------------------------------------------------
`define RCS_BIT_POR 7
`define RCS_BIT_STOP 6
`define RCS_BIT_WDT 5
`define RCS_BIT_EXT 4

// ----------------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------------
`define RCS_CTL_WDT_EN 0
`define RCS_CTL_WDT_OSC_EN 1
`define RCS_CTL_DROOP_EN 2
`define RCS_CTL_HALT 3
`define RCS_CTL_XTAL_EN 4

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RCS_CTRL_RESET 8'h07
`define RCS_MASK_RESET 8'h00
`define RCS_SEQ_NS 1000
`define RCS_CLK_NS 50
`define RCS_SEQ_CYCLES ((`RCS_SEQ_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)

`endif

// *** rtl/rcs_core.sv ***
/*
 * Reset-cause tracking and low-power mode control, APB slave.
 * Assumes the droop detector, watchdog, reset pin and stop/halt
 * instruction decode arrive as synchronous levels or one-cycle pulses,
 * and that droop_detect_in_stop is a static nonvolatile option.
 */
// Design decisions made here: the APB slave port and the placing of the registers.
// Overview of operation
// - Droop below threshold forces and holds reset.
// - After supply returns, sequence then set power-up.
// - Option bit keeps droop detector in stop.
// - Stop recovery sets stop flag; watchdog tells cause.
// - Stop flag cleared by POR, awake timeout, read.
// - Watchdog flag set on timeout, cleared by POR, pin recovery, read.
// - External reset flag set by pin, cleared likewise.
// - Stop powers all down except droop, watchdog.
// - Stop halts oscillators, clock, CPU, program counter.
// - Stop disables crystal pins, port A reverts.
// - Watchdog oscillator and logic run if enabled.
// - Halt stops only CPU; active otherwise.
// - Stop exits through stop recovery, the external reset pin, or droop with option.
`timescale 1ns/1ps
`include "rcs_regs.svh"

module rcs_core #(
  parameter int SEQ_CYCLES = `RCS_SEQ_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic DROOP_LOW,
  input wire logic SUPPLY_ABOVE_POR,
  input wire logic DROOP_DETECT_IN_STOP,
  input wire logic EXT_RESET_PIN,
  input wire logic WDT_TIMEOUT,
  input wire logic STOP_EXEC,
  input wire logic HALT_EXIT,
  input wire logic RECOVER_PIN,
  output logic SYS_RESET,
  output logic CPU_CLK_EN,
  output logic SYS_CLK_EN,
  output logic XTAL_OSC_EN,
  output logic IPO_EN,
  output logic XTAL_PINS_EN,
  output logic PORTA_GPIO,
  output logic PERIPH_EN,
  output logic WDT_OSC_RUN,
  output logic WDT_RUN,
  output logic DROOP_RUN,
  output logic IRQ
);

  rcs_pkg::rcs_state_type s_q, s_d;
  rcs_pkg::rcs_power_type pwr;

  logic setup;
  logic access;
  logic rd_status;
  logic in_stop;
  logic droop_active;
  logic wdt_in_stop;
  logic stop_recover;
  logic [7:0] events;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign rd_status = access && !PWRITE && hit(PADDR, `RCS_OFF_STATUS);
  assign PREADY = 1'b1;
  assign PSLVERR = access && !(hit(PADDR, `RCS_OFF_STATUS) ||
    hit(PADDR, `RCS_OFF_CTRL) || hit(PADDR, `RCS_OFF_IRQ_STAT) ||
    hit(PADDR, `RCS_OFF_IRQ_MASK));
  assign PRDATA = s_q.prdata;

  assign in_stop = (s_q.mode == rcs_pkg::ST_STOP);
  // Droop detector only counts in stop when the option keeps it alive
  assign droop_active = DROOP_LOW &&
    (!in_stop || DROOP_DETECT_IN_STOP);
  assign wdt_in_stop = WDT_TIMEOUT && in_stop && s_q.ctrl[`RCS_CTL_WDT_EN];
  // Recovery from stop: watchdog timeout or pin change only
  assign stop_recover = in_stop && (wdt_in_stop || RECOVER_PIN);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    events = 8'h00;
    if (PSEL && PENABLE) begin
      s_d.prdata = 32'h0000_0000;
    end
    // Read clears only the bits it reported, so an event between setup
    // and access is kept; events set below win over the clear
    if (rd_status) begin
      s_d.cause = s_q.cause & ~s_q.prdata[7:0];
    end
    case (s_q.mode)
      rcs_pkg::ST_RESET: begin
        // Held in reset while supply stays under the power-up threshold
        if (SUPPLY_ABOVE_POR && !DROOP_LOW) begin
          s_d.mode = rcs_pkg::ST_SEQ;
          s_d.seq_cnt = 8'h00;
        end
      end
      rcs_pkg::ST_SEQ: begin
        if (s_q.seq_cnt == 8'(SEQ_CYCLES - 1)) begin
          s_d.mode = rcs_pkg::ST_ACTIVE;
          s_d.cause = 8'h00;
          s_d.cause[`RCS_BIT_POR] = 1'b1;
          s_d.cause[`RCS_BIT_EXT] = s_q.ext_pend;
          s_d.ext_pend = 1'b0;
          events[`RCS_BIT_POR] = 1'b1;
          events[`RCS_BIT_EXT] = s_q.ext_pend;
        end else begin
          s_d.seq_cnt = s_q.seq_cnt + 8'h01;
        end
      end
      rcs_pkg::ST_ACTIVE: begin
        if (STOP_EXEC) begin
          s_d.mode = rcs_pkg::ST_STOP;
        end else if (s_q.ctrl[`RCS_CTL_HALT]) begin
          s_d.mode = rcs_pkg::ST_HALT;
          s_d.ctrl[`RCS_CTL_HALT] = 1'b0;
        end
      end
      rcs_pkg::ST_HALT: begin
        if (HALT_EXIT) begin
          s_d.mode = rcs_pkg::ST_ACTIVE;
        end
      end
      rcs_pkg::ST_STOP: begin
        if (stop_recover) begin
          s_d.mode = rcs_pkg::ST_ACTIVE;
        end
      end
      default: begin
        s_d.mode = rcs_pkg::ST_RESET;
      end
    endcase

    if (stop_recover) begin
      s_d.cause[`RCS_BIT_STOP] = 1'b1;
      events[`RCS_BIT_STOP] = 1'b1;
      if (wdt_in_stop) begin
        s_d.cause[`RCS_BIT_WDT] = 1'b1;
        events[`RCS_BIT_WDT] = 1'b1;
      end else begin
        s_d.cause[`RCS_BIT_WDT] = 1'b0;
        s_d.cause[`RCS_BIT_EXT] = 1'b0;
      end
    end
    if (WDT_TIMEOUT && !in_stop && s_q.ctrl[`RCS_CTL_WDT_EN] &&
        (s_q.mode == rcs_pkg::ST_ACTIVE || s_q.mode == rcs_pkg::ST_HALT)) begin
      s_d.cause[`RCS_BIT_STOP] = 1'b0;
      s_d.cause[`RCS_BIT_WDT] = 1'b1;
      events[`RCS_BIT_WDT] = 1'b1;
    end

    // External pin reset restarts the sequence, remembering the cause
    if (EXT_RESET_PIN && s_q.mode != rcs_pkg::ST_RESET) begin
      s_d.mode = rcs_pkg::ST_SEQ;
      s_d.seq_cnt = 8'h00;
      s_d.ext_pend = 1'b1;
    end
    // Droop wins over every mode change and cause update and wipes the causes, as power-up does
    if (droop_active) begin
      s_d.mode = rcs_pkg::ST_RESET;
      s_d.cause = 8'h00;
      s_d.ext_pend = 1'b0;
    end

    // Register file
    if (access && PWRITE) begin
      if (hit(PADDR, `RCS_OFF_CTRL)) begin
        s_d.ctrl = PWDATA[7:0];
      end
      if (hit(PADDR, `RCS_OFF_IRQ_MASK)) begin
        s_d.irq_mask = PWDATA[7:0];
      end
    end
    if (setup && !PWRITE) begin
      if (hit(PADDR, `RCS_OFF_STATUS)) begin
        s_d.prdata = {24'h00_0000, s_q.cause};
      end else if (hit(PADDR, `RCS_OFF_CTRL)) begin
        s_d.prdata = {24'h00_0000, s_q.ctrl};
      end else if (hit(PADDR, `RCS_OFF_IRQ_STAT)) begin
        s_d.prdata = {24'h00_0000, s_q.irq_stat};
      end else if (hit(PADDR, `RCS_OFF_IRQ_MASK)) begin
        s_d.prdata = {24'h00_0000, s_q.irq_mask};
      end else begin
        s_d.prdata = 32'h0000_0000;
      end
    end
    // Read of the interrupt status clears it; new events win
    if (access && !PWRITE && hit(PADDR, `RCS_OFF_IRQ_STAT)) begin
      s_d.irq_stat = s_q.irq_stat & ~s_q.prdata[7:0];
    end
    s_d.irq_stat = s_d.irq_stat | events;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s_q <= '{mode: rcs_pkg::ST_RESET, cause: 8'h00,
               ctrl: `RCS_CTRL_RESET, irq_stat: 8'h00,
               irq_mask: `RCS_MASK_RESET, seq_cnt: 8'h00,
               prdata: 32'h0000_0000, ext_pend: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Power and clock gating
  // ----------------------------------------------------------------------
  // Software must read the status before acknowledging the watchdog
  // interrupt; nothing here enforces it.
  always_comb begin
    pwr.cpu_clk_en = (s_q.mode == rcs_pkg::ST_ACTIVE);
    pwr.sys_clk_en = !in_stop && s_q.mode != rcs_pkg::ST_RESET;
    pwr.xtal_osc_en = !in_stop && s_q.ctrl[`RCS_CTL_XTAL_EN];
    pwr.ipo_en = !in_stop;
    pwr.xtal_pins_en = !in_stop && s_q.ctrl[`RCS_CTL_XTAL_EN];
    pwr.porta_gpio = in_stop || !s_q.ctrl[`RCS_CTL_XTAL_EN];
    pwr.periph_en = !in_stop && s_q.mode != rcs_pkg::ST_RESET;
    pwr.wdt_osc_run = s_q.ctrl[`RCS_CTL_WDT_OSC_EN];
    pwr.wdt_run = s_q.ctrl[`RCS_CTL_WDT_EN];
    pwr.droop_run = s_q.ctrl[`RCS_CTL_DROOP_EN] &&
      (!in_stop || DROOP_DETECT_IN_STOP);
  end

  assign SYS_RESET = (s_q.mode == rcs_pkg::ST_RESET) ||
    (s_q.mode == rcs_pkg::ST_SEQ);
  assign CPU_CLK_EN = pwr.cpu_clk_en;
  assign SYS_CLK_EN = pwr.sys_clk_en;
  assign XTAL_OSC_EN = pwr.xtal_osc_en;
  assign IPO_EN = pwr.ipo_en;
  assign XTAL_PINS_EN = pwr.xtal_pins_en;
  assign PORTA_GPIO = pwr.porta_gpio;
  assign PERIPH_EN = pwr.periph_en;
  assign WDT_OSC_RUN = pwr.wdt_osc_run;
  assign WDT_RUN = pwr.wdt_run;
  assign DROOP_RUN = pwr.droop_run;
  assign IRQ = |(s_q.irq_stat & s_q.irq_mask);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_droop_reset: assert property (
    @(posedge CLOCK) disable iff (RST)
    (DROOP_LOW && !in_stop) |=> (s_q.mode == rcs_pkg::ST_RESET && SYS_RESET))
    else $error("droop did not force reset");

  chk_por_flag: assert property (
    @(posedge CLOCK) disable iff (RST)
    (s_q.mode == rcs_pkg::ST_SEQ && $past(s_q.mode) == rcs_pkg::ST_RESET &&
     !DROOP_LOW && !EXT_RESET_PIN) ##1 (!DROOP_LOW && !EXT_RESET_PIN)[*3]
    |-> ##[1:60] s_q.cause[`RCS_BIT_POR])
    else $error("power-up flag not set after sequence");

  chk_stop_set: assert property (
    @(posedge CLOCK) disable iff (RST)
    (stop_recover && !droop_active && !EXT_RESET_PIN)
    |=> s_q.cause[`RCS_BIT_STOP] && s_q.mode == rcs_pkg::ST_ACTIVE)
    else $error("stop recovery flag not set");

  chk_read_clear: assert property (
    @(posedge CLOCK) disable iff (RST)
    (rd_status && !stop_recover && !WDT_TIMEOUT && !(s_q.mode ==
     rcs_pkg::ST_SEQ) && !EXT_RESET_PIN &&
     s_q.cause == s_q.prdata[7:0]) |=> s_q.cause == 8'h00)
    else $error("status read did not clear flags");

  chk_wdt_set: assert property (
    @(posedge CLOCK) disable iff (RST)
    (WDT_TIMEOUT && s_q.ctrl[`RCS_CTL_WDT_EN] && !droop_active &&
     s_q.mode inside {rcs_pkg::ST_ACTIVE, rcs_pkg::ST_HALT,
     rcs_pkg::ST_STOP}) |=> s_q.cause[`RCS_BIT_WDT])
    else $error("watchdog flag lost");

  chk_pin_clear: assert property (
    @(posedge CLOCK) disable iff (RST)
    (stop_recover && !wdt_in_stop && !EXT_RESET_PIN && !droop_active)
    |=> !s_q.cause[`RCS_BIT_EXT] && !s_q.cause[`RCS_BIT_WDT])
    else $error("pin recovery left flags set");

  chk_stop_gate: assert property (
    @(posedge CLOCK) disable iff (RST)
    in_stop |-> !CPU_CLK_EN && !SYS_CLK_EN && !IPO_EN && !XTAL_PINS_EN &&
    PORTA_GPIO && !PERIPH_EN)
    else $error("stop mode left clocks running");

  chk_stop_hold: assert property (
    @(posedge CLOCK) disable iff (RST)
    (in_stop && !stop_recover && !droop_active && !EXT_RESET_PIN)
    |=> in_stop)
    else $error("stop exited without recovery");

  chk_halt_cpu: assert property (
    @(posedge CLOCK) disable iff (RST)
    (s_q.mode == rcs_pkg::ST_HALT) |-> !CPU_CLK_EN && SYS_CLK_EN)
    else $error("halt gated more than the cpu");

  chk_droop_hold: assert property (
    @(posedge CLOCK) disable iff (RST)
    (s_q.mode == rcs_pkg::ST_RESET && !SUPPLY_ABOVE_POR)
    |=> s_q.mode == rcs_pkg::ST_RESET)
    else $error("reset left below power-up threshold");

  chk_droop_off: assert property (
    @(posedge CLOCK) disable iff (RST)
    (in_stop && !DROOP_DETECT_IN_STOP) |-> !DROOP_RUN)
    else $error("droop detector ran in stop without option");

  chk_xtal_active: assert property (
    @(posedge CLOCK) disable iff (RST)
    (s_q.mode == rcs_pkg::ST_ACTIVE && s_q.ctrl[`RCS_CTL_XTAL_EN])
    |-> XTAL_PINS_EN && XTAL_OSC_EN && !PORTA_GPIO)
    else $error("crystal pins not in use while enabled");

  chk_wdt_stop: assert property (
    @(posedge CLOCK) disable iff (RST)
    (in_stop && s_q.ctrl[`RCS_CTL_WDT_EN] && s_q.ctrl[`RCS_CTL_WDT_OSC_EN])
    |-> WDT_RUN && WDT_OSC_RUN)
    else $error("watchdog stopped in stop while enabled");

  chk_halt_entry: assert property (
    @(posedge CLOCK) disable iff (RST)
    (s_q.mode == rcs_pkg::ST_ACTIVE && s_q.ctrl[`RCS_CTL_HALT] &&
     !STOP_EXEC && !EXT_RESET_PIN && !droop_active && !(access && PWRITE))
    |=> s_q.mode == rcs_pkg::ST_HALT && !s_q.ctrl[`RCS_CTL_HALT])
    else $error("halt request not taken");

  chk_irq_keep: assert property (
    @(posedge CLOCK) disable iff (RST)
    (access && !PWRITE && hit(PADDR, `RCS_OFF_IRQ_STAT) && WDT_TIMEOUT &&
     s_q.ctrl[`RCS_CTL_WDT_EN] && !droop_active &&
     s_q.mode inside {rcs_pkg::ST_ACTIVE, rcs_pkg::ST_HALT, rcs_pkg::ST_STOP})
    |=> s_q.irq_stat[`RCS_BIT_WDT])
    else $error("watchdog event lost to interrupt read");

endmodule : rcs_core
